// ---- rtl/sio_three_wire.sv ----
/*
   Eight-bit three-wire clocked serial port: control register, shift data
   register, master clock divider or slave clock input, MSB-first shifting
   and a transfer-done flag, with a small FIFO ahead of the transmit path.
   Assumes a CPU-side register port on CLK, pin inputs from outside the
   clock domain and a pad ring that turns the enables into two-way pins.
*/
// Notes on behaviour
// (R1) Each transfer moves eight bits, sending and receiving together through one shift register.
// (R2) The most significant bit always goes first, with no order option.
// (R3) The shift register advances on each serial clock fall, the output latch driving the pin.
// (R4) The input pin is sampled on each serial clock rise into the shift register.
// (R5) After eight bits the port stops by itself and sets the transfer-done flag.
// (R6) Enable bit 7 clear stops shifting, clears the bit count and frees the pins.
// (R7) Enabled and not receive-only, a data write starts a transfer with normal output.
// (R8) Enabled and receive-only, a data read starts a transfer with the output held low.
// (R9) Clock select 00 takes the external clock, 01/10/11 divide CLK by 8, 16 or 32.
// (R10) A transfer starts only once the last one ended with the clock stopped or high.
// (R11) A data write made while disabled never starts a transfer later.
// (R12) Reset clears the control register and clears the shift data to zero.
// (R13) Software touches the data register during a transfer only to start one.
// (R14) Software never enables this port and the asynchronous serial unit together.
// (R15) When enabled, the unused data pin stays free for port use.
// (R16) Software sets pin directions and latches to suit master, slave, send or receive.
// (R17) The serial clock idles high and carries exactly eight pulses per transfer.
`timescale 1ns/100ps
`include "sio_defines.svh"
module sio_three_wire
   import sio_pkg::*;
#(
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        SRST,
   // CPU register port
   input  wire logic [15:0] REG_ADDR,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [7:0]  REG_WDATA,
   output      logic [7:0]  REG_RDATA,
   output      logic        REG_RVALID,
   output      logic        WR_READY,
   // Transfer status
   output      logic        DONE_FLAG,
   input  wire logic        DONE_CLR,
   output      logic        BUSY,
   // Serial pins
   input  wire logic        SCK_IN,
   output      logic        SCK_OUT,
   output      logic        SCK_OE,
   output      logic        SO_OUT,
   output      logic        SO_OE,
   input  wire logic        SI_IN
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("sio_three_wire: FIFO_DEPTH must be a power of two of at least 2");
   end

   // ----------------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------------

   // Half period of the master clock in CLK cycles for a source code
   function automatic logic [4:0] half_period(input logic [1:0] sel);
      logic [4:0] h;
      h = `SIO_HALF_DIV32;
      if (sel == `SIO_CLK_DIV8) begin
         h = `SIO_HALF_DIV8;
      end else if (sel == `SIO_CLK_DIV16) begin
         h = `SIO_HALF_DIV16;
      end
      return h;
   endfunction

   // Address match, used for both reads and writes
   function automatic logic hit(input logic [15:0] addr, input logic [15:0] reg_addr);
      return addr == reg_addr;
   endfunction

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   sio_state_t s_q;
   sio_state_t s_d;
   logic       master;
   logic       start_ok;
   logic       tx_pop;
   logic       wr_data;
   logic       rd_data;

   byte_stream_if #(.WIDTH(8)) wr_s ();
   byte_stream_if #(.WIDTH(8)) tx_s ();

   // ----------------------------------------------------------------------
   // Transmit FIFO
   // ----------------------------------------------------------------------

   // Writes queue here; the engine drains one byte per transfer, and a
   // write made while WR_READY is low is refused and dropped
   sio_tx_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .CLK   (CLK),
      .SRST  (SRST),
      .FLUSH (!s_q.en),
      .in_s  (wr_s.snk),
      .out_s (tx_s.src)
   );

   // Data writes count only while enabled in send mode; a write made while
   // disabled is dropped so it cannot fire when the port is enabled later
   assign wr_data    = REG_WR & hit(REG_ADDR, `SIO_ADDR_SHIFT_DATA);
   assign rd_data    = REG_RD & hit(REG_ADDR, `SIO_ADDR_SHIFT_DATA);
   assign wr_s.valid = wr_data & s_q.en & !s_q.rxonly;            // R7 R11
   assign wr_s.data  = REG_WDATA;

   // ----------------------------------------------------------------------
   // Start conditions
   // ----------------------------------------------------------------------

   // A new transfer waits for an idle engine and, as slave, a high clock
   assign master   = (s_q.clksel != `SIO_CLK_EXTERNAL);              // R9
   assign start_ok = (s_q.st == ST_IDLE) & s_q.en
                     & (master | s_q.sck_sync[1]);                     // R10
   assign tx_pop   = start_ok & !s_q.rxonly & tx_s.valid;             // R7
   assign tx_s.ready = tx_pop;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      logic fall;
      logic rise;
      fall     = 1'b0;
      rise     = 1'b0;
      s_d      = s_q;
      s_d.rvalid = 1'b0;

      // Pin synchronisers; the first stage feeds only the second
      s_d.sck_sync = {s_q.sck_sync[0], SCK_IN};
      s_d.si_sync  = {s_q.si_sync[0], SI_IN};
      s_d.sck_prev = s_q.sck_sync[1];

      // Control register write
      if (REG_WR && hit(REG_ADDR, `SIO_ADDR_MODE_CTRL)) begin
         s_d.en     = REG_WDATA[`SIO_BIT_ENABLE];                      // R6
         s_d.rxonly = REG_WDATA[`SIO_BIT_RXONLY];
         s_d.clksel = {REG_WDATA[`SIO_BIT_CLKSEL_HI], REG_WDATA[`SIO_BIT_CLKSEL_LO]};
      end

      // Register reads answer one cycle later; unused bits read zero
      if (REG_RD) begin
         s_d.rvalid = 1'b1;
         if (hit(REG_ADDR, `SIO_ADDR_MODE_CTRL)) begin
            s_d.rdata = {s_q.en, `SIO_CTRL_ZERO4, s_q.rxonly, s_q.clksel};
         end else if (rd_data) begin
            s_d.rdata = s_q.sh;
         end else begin
            s_d.rdata = `SIO_READ_UNMAPPED;
         end
      end

      // Receive-only trigger is remembered until the clock line allows it
      if (rd_data && s_q.en && s_q.rxonly && s_q.st == ST_IDLE) begin
         s_d.rd_pend = 1'b1;                                           // R8
      end

      unique case (s_q.st)
         ST_IDLE: begin
            s_d.sck  = 1'b1;                                           // R17
            s_d.div  = '0;
            s_d.bits = '0;
            if (tx_pop) begin
               s_d.sh = tx_s.data;                                     // R7
               s_d.st = ST_SHIFT;
            end else if (s_q.rd_pend && start_ok && s_q.rxonly) begin
               s_d.rd_pend = 1'b0;                                     // R8
               s_d.st      = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            // Edge source: own divider as master, synchronised pin as slave
            if (master) begin
               if (s_q.div == half_period(s_q.clksel) - `SIO_DIV_ONE) begin
                  s_d.div = '0;
                  s_d.sck = !s_q.sck;                                  // R9
                  fall    = s_q.sck;
                  rise    = !s_q.sck;
               end else begin
                  s_d.div = s_q.div + 1'b1;
               end
            end else begin
               fall = s_q.sck_prev & !s_q.sck_sync[1];
               rise = !s_q.sck_prev & s_q.sck_sync[1];
            end

            // Falling edge: top bit to the output latch, register shifts up
            if (fall) begin
               s_d.so = s_q.rxonly ? 1'b0 : s_q.sh[7];                 // R2 R3 R8
               s_d.sh = {s_q.sh[6:0], 1'b0};                           // R3
            end

            // Rising edge: input bit lands in the vacated low bit
            if (rise) begin
               s_d.sh[0] = s_q.si_sync[1];                             // R4
               s_d.bits  = s_q.bits + `SIO_BIT_ONE;
               if (s_q.bits == `SIO_LAST_BIT) begin
                  s_d.st = ST_IDLE;                                    // R1 R5 R17
               end
            end
         end
      endcase

      // Done flag: a completion in the clearing cycle still sets it
      s_d.done = (s_q.st == ST_SHIFT && s_d.st == ST_IDLE)
                 | (s_q.done & !DONE_CLR);                             // R5

      // Disabled: stop at once, clear the count, drop any pending start
      if (!s_q.en) begin
         s_d.st      = ST_IDLE;                                        // R6
         s_d.bits    = '0;
         s_d.div     = '0;
         s_d.rd_pend = 1'b0;
         s_d.sck     = 1'b1;
      end

      // Pin drivers: only the pins the current mode needs are taken
      s_d.sck_oe = s_d.en & (s_d.clksel != `SIO_CLK_EXTERNAL);         // R6 R9
      s_d.so_oe  = s_d.en & !s_d.rxonly;                               // R15
      if (s_d.rxonly) begin
         s_d.so = 1'b0;                                                // R8
      end
      s_d.busy = (s_d.st == ST_SHIFT);
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------

   // Reset clears the control fields and parks the clock high
   always_ff @(posedge CLK) begin
      if (SRST) begin
         s_q     <= '0;                                                // R12
         s_q.sck <= 1'b1;                                              // R17
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs, each straight from a flop
   // ----------------------------------------------------------------------
   assign REG_RDATA  = s_q.rdata;
   assign REG_RVALID = s_q.rvalid;
   assign WR_READY   = wr_s.ready;
   assign DONE_FLAG  = s_q.done;
   assign BUSY       = s_q.busy;
   assign SCK_OUT    = s_q.sck;
   assign SCK_OE     = s_q.sck_oe;
   assign SO_OUT     = s_q.so;
   assign SO_OE      = s_q.so_oe;

endmodule

// ---- rtl/sio_defines.svh ----
/*
   Constants of the three-wire serial port: register addresses, field
   positions, reset values, clock-select codes and transfer counts.
   Assumes it is included by bare name wherever the port logic needs them.
*/
`ifndef SIO_DEFINES_SVH
`define SIO_DEFINES_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define SIO_ADDR_MODE_CTRL   16'hFFB8
`define SIO_ADDR_SHIFT_DATA  16'hFFB9

// ----------------------------------------------------------------------
// Control register fields and reset value
// ----------------------------------------------------------------------
`define SIO_CTRL_RESET       8'h00
`define SIO_BIT_ENABLE       7
`define SIO_BIT_RXONLY       2
`define SIO_BIT_CLKSEL_HI    1
`define SIO_BIT_CLKSEL_LO    0
`define SIO_CTRL_ZERO4       4'h0
`define SIO_READ_UNMAPPED    8'h00

// ----------------------------------------------------------------------
// Clock source codes and master half periods in CLK cycles
// ----------------------------------------------------------------------
`define SIO_CLK_EXTERNAL     2'h0
`define SIO_CLK_DIV8         2'h1
`define SIO_CLK_DIV16        2'h2
`define SIO_HALF_DIV8        5'h04
`define SIO_HALF_DIV16       5'h08
`define SIO_HALF_DIV32       5'h10
`define SIO_DIV_ONE          5'h01

// ----------------------------------------------------------------------
// Transfer size
// ----------------------------------------------------------------------
`define SIO_LAST_BIT         4'h7
`define SIO_BIT_ONE          4'h1

`endif

// ---- rtl/sio_pkg.sv ----
/*
   Types shared by the three-wire serial port: transfer states and the
   packed state record of the port engine.
   Assumes nothing beyond a SystemVerilog compiler.
*/
package sio_pkg;

   // Transfer engine states
   typedef enum logic {
      ST_IDLE,
      ST_SHIFT
   } xfer_state_t;

   // Whole state of the port engine, registered in one process
   typedef struct packed {
      xfer_state_t st;
      logic        en;
      logic        rxonly;
      logic [1:0]  clksel;
      logic [7:0]  sh;
      logic [3:0]  bits;
      logic [4:0]  div;
      logic        sck;
      logic        sck_oe;
      logic        so;
      logic        so_oe;
      logic        done;
      logic        busy;
      logic        rd_pend;
      logic [7:0]  rdata;
      logic        rvalid;
      logic [1:0]  sck_sync;
      logic        sck_prev;
      logic [1:0]  si_sync;
   } sio_state_t;

endpackage

// ---- rtl/byte_stream_if.sv ----
/*
   Valid/ready byte stream joining the port engine and its transmit FIFO.
   Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
interface byte_stream_if #(
   parameter int WIDTH = 8
);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ---- rtl/sio_tx_fifo.sv ----
/*
   Small synchronous FIFO holding transmit bytes ahead of the shift engine.
   Assumes one clock, a synchronous active-high reset and a power-of-two depth.
*/
`timescale 1ns/100ps
module sio_tx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic   CLK,
   input wire logic   SRST,
   input wire logic   FLUSH,
   // Streams
   byte_stream_if.snk in_s,
   byte_stream_if.src out_s
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointer wrap relies on a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("sio_tx_fifo: DEPTH must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
      logic                        in_rdy;
      logic                        out_vld;
   } fifo_state_t;

   fifo_state_t s_q;
   fifo_state_t s_d;
   logic        push;
   logic        pop;

   // Handshakes; ready and valid come straight from flops
   assign push        = in_s.valid & s_q.in_rdy;
   assign pop         = out_s.ready & s_q.out_vld;
   assign in_s.ready  = s_q.in_rdy;
   assign out_s.valid = s_q.out_vld;
   assign out_s.data  = s_q.mem[s_q.rp];

   // Next state; flush drops everything queued
   always_comb begin
      s_d = s_q;
      if (FLUSH) begin
         s_d.wp  = '0;
         s_d.rp  = '0;
         s_d.cnt = '0;
      end else begin
         if (push) begin
            s_d.mem[s_q.wp] = in_s.data;
            s_d.wp          = s_q.wp + 1'b1;
         end
         if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
         end
         if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
         end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
         end
      end
      s_d.in_rdy  = (s_d.cnt != (AW+1)'(DEPTH));
      s_d.out_vld = (s_d.cnt != '0);
   end

   // State register
   always_ff @(posedge CLK) begin
      if (SRST) begin
         s_q        <= '0;
         s_q.in_rdy <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// ---- dv/sio_three_wire_properties.sv ----
/*
   Checker of the three-wire serial port, watching its top-level ports.
   Assumes one clock, a synchronous reset and the port's register map.
*/
`timescale 1ns/100ps
module sio_three_wire_properties (
   // Clock and reset
   input wire logic        CLK,
   input wire logic        SRST,
   // Register port
   input wire logic [15:0] REG_ADDR,
   input wire logic        REG_WR,
   input wire logic        REG_RD,
   input wire logic [7:0]  REG_WDATA,
   // Status and pins
   input wire logic        DONE_FLAG,
   input wire logic        BUSY,
   input wire logic        SCK_OUT,
   input wire logic        SCK_OE,
   input wire logic        SO_OUT,
   input wire logic        SO_OE
);
   // ----------------------------------------
   // Shadow of the control register
   // ----------------------------------------
   logic [7:0] ctrl_q;
   logic [3:0] rise_q;
   logic       en_w;
   logic       rxo_w;
   logic       dwr_w;
   assign en_w  = ctrl_q[7];
   assign rxo_w = ctrl_q[7] & ctrl_q[2];
   assign dwr_w = REG_WR && REG_ADDR == 16'hFFB9;
   // Rises are counted per transfer so a short or long burst shows up
   always_ff @(posedge CLK) begin
      if (SRST) begin
         ctrl_q <= 8'h00;
         rise_q <= 4'h0;
      end else begin
         if (REG_WR && REG_ADDR == 16'hFFB8) ctrl_q <= REG_WDATA & 8'h87;
         if ($rose(BUSY)) rise_q <= 4'h0;
         else if ($rose(SCK_OUT) && rise_q != 4'hF) rise_q <= rise_q + 4'h1;
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   // ----------------------------------------
   // Clock shape sequences
   // ----------------------------------------
   sequence low4_s;
      ##1 !SCK_OUT[*3] ##1 SCK_OUT;
   endsequence
   sequence high8_s;
      ##1 SCK_OUT[*7] ##1 !SCK_OUT;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_idle_clk_high: assert property (!BUSY && !$fell(BUSY) |-> SCK_OUT)
      else $error("serial clock low while idle");
   a_done_ends_busy: assert property ($rose(DONE_FLAG) |-> $fell(BUSY))
      else $error("done flag without end of transfer");
   a_eight_pulses: assert property ($fell(BUSY) && en_w && SCK_OE |=> rise_q == 4'h8)
      else $error("transfer did not carry eight clock pulses");
   a_div8_low: assert property ($fell(SCK_OUT) && ctrl_q[1:0] == 2'h1 |-> low4_s)
      else $error("divide-by-8 low phase wrong");
   a_div16_high: assert property ($rose(SCK_OUT) && BUSY && ctrl_q[1:0] == 2'h2 |-> high8_s)
      else $error("divide-by-16 high phase wrong");
   a_write_starts: assert property (dwr_w && en_w && !ctrl_q[2] && !BUSY && SCK_OE
      |-> ##[1:3] BUSY)
      else $error("data write did not start a transfer");
   a_read_starts: assert property (REG_RD && REG_ADDR == 16'hFFB9 && rxo_w && !BUSY && SCK_OE
      |-> ##[1:3] BUSY)
      else $error("data read did not start a receive");
   a_rxonly_low: assert property (rxo_w && $past(rxo_w, 2) |-> !SO_OUT)
      else $error("serial out not low in receive-only mode");
   a_off_quiet: assert property (!en_w && !$past(en_w) |-> !SCK_OE && !SO_OE && !BUSY)
      else $error("disabled port still active");
   a_no_late_start: assert property (dwr_w && !en_w |=> !BUSY[*6])
      else $error("write made while disabled started a transfer");
endmodule
bind sio_three_wire sio_three_wire_properties i_props (
   .CLK(CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_WDATA(REG_WDATA), .DONE_FLAG(DONE_FLAG), .BUSY(BUSY), .SCK_OUT(SCK_OUT),
   .SCK_OE(SCK_OE), .SO_OUT(SO_OUT), .SO_OE(SO_OE)
);

// ---- dv/sio_peer.sv ----
/*
   Behavioural clocked-serial peripheral on the far side of the port.
   Assumes the serial clock idles high and the bench pulses load per frame.
*/
`timescale 1ns/100ps
module sio_peer (
   // Link
   input  wire logic       sck,
   input  wire logic       so,
   output logic            si,
   // Bench side
   input  wire logic       load,
   input  wire logic [7:0] tx,
   output logic [7:0]      rx
);
   logic [2:0] idx_q;
   initial begin
      idx_q = 3'h7;
      si = 1'b1;
      rx = 8'h00;
   end
   // Frame alignment after an abort or a mode change
   always @(posedge load) idx_q = 3'h7;
   // Next bit on each fall, most significant first
   always @(negedge sck) begin
      si <= tx[idx_q];
      idx_q <= idx_q - 3'h1;
   end
   // Sample on each rise; after the last bit the line is let go and wanders
   always @(posedge sck) begin
      rx <= {rx[6:0], so};
      if (idx_q == 3'h7) si <= #200 ~si;
   end
endmodule

// ---- dv/sio_three_wire_bench.sv ----
/*
   Self-checking bench of the three-wire serial port.
   Assumes the peer model and the checker are compiled before it.
*/
`timescale 1ns/100ps
module sio_three_wire_bench;
   // ----------------------------------------
   // Signals and rows
   // ----------------------------------------
   logic        clk, srst, wr_s, rd_s, done_clr, sck_ext, load;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, peer_tx, peer_rx, rd_v, last;
   logic        rvalid, wr_ready, done, busy, sck_out, sck_oe, so_out, so_oe, si, pb;
   // Pin direction follows the mode: driven clock as master, bench clock as slave
   wire         sck_w = sck_oe ? sck_out : sck_ext;
   int          errors, n_compared, n, acc, fr, t;
   typedef struct packed { logic [7:0] ctrl, tx, peer; } row_t;
   // Control, byte sent, byte the peer returns
   row_t rows [4] = '{'{8'h81, 8'hA5, 8'h3C}, '{8'h82, 8'h01, 8'h80},
                      '{8'h83, 8'hFF, 8'h00}, '{8'h85, 8'h5A, 8'hC3}};
   sio_three_wire #(.FIFO_DEPTH(4)) i_dut (
      .CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WR(wr_s), .REG_RD(rd_s),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .WR_READY(wr_ready),
      .DONE_FLAG(done), .DONE_CLR(done_clr), .BUSY(busy), .SCK_IN(sck_w),
      .SCK_OUT(sck_out), .SCK_OE(sck_oe), .SO_OUT(so_out), .SO_OE(so_oe), .SI_IN(si));
   sio_peer i_peer (.sck(sck_w), .so(so_out), .si(si), .load(load), .tx(peer_tx), .rx(peer_rx));
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic fail(input string m);
      errors++;
      $display("[ERR] %0t %s", $time, m);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   // Read data is taken at the falling edge after the edge that carries the answer
   task automatic rd(input logic [15:0] a);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      if (rvalid !== 1'b1) fail("no read answer");
      rd_v = rdata;
   endtask
   task automatic pulse_load;
      @(posedge clk);
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
   endtask
   // Busy cycles are counted while waiting, with a bound
   task automatic wait_done(output int cnt);
      cnt = 0;
      for (t = 0; t < 4000 && done !== 1'b1; t++) begin
         @(negedge clk);
         if (busy === 1'b1) cnt++;
      end
      if (done !== 1'b1) fail("transfer never finished");
   endtask
   task automatic final_report;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fail("timeout");
      final_report;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   // The shared asynchronous unit is never modelled, so it is never enabled alongside
   initial begin
      {srst, wr_s, rd_s, done_clr, load} = 5'h10;
      sck_ext = 1'b1;
      {addr, wdata, peer_tx} = 32'h0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      foreach (rows[i]) begin
         wr(16'hFFB8, rows[i].ctrl);
         peer_tx <= rows[i].peer;
         pulse_load;
         chk({sck_oe, so_oe}, {1'b1, !rows[i].ctrl[2]});
         if (rows[i].ctrl[2]) rd(16'hFFB9);
         else wr(16'hFFB9, rows[i].tx);
         wait_done(n);
         chk(16'(n), 16'd64 << (rows[i].ctrl[1:0] - 2'h1));
         chk(peer_rx, rows[i].ctrl[2] ? 8'h00 : rows[i].tx);
         rd(16'hFFB9);
         chk(rd_v, rows[i].peer);
         wr(16'hFFB8, 8'h00);
         @(posedge clk);
         done_clr <= 1'b1;
         @(posedge clk);
         done_clr <= 1'b0;
         @(negedge clk);
         chk(done, 1'b0);
      end
      // Mid-run reset clears the control register
      wr(16'hFFB8, 8'h83);
      srst <= 1'b1;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      rd(16'hFFB8);
      chk(rd_v, 8'h00);
      rd(16'hFF00);
      chk(rd_v, 8'h00);
      chk({sck_out, sck_oe}, 2'h2);
      // A write while disabled is not replayed on enable
      wr(16'hFFB9, 8'h55);
      wr(16'hFFB8, 8'h81);
      repeat (20) @(negedge clk);
      chk({busy, done}, 2'h0);
      // Abort mid-transfer; reserved bits read back as zero
      wr(16'hFFB8, 8'h83);
      wr(16'hFFB9, 8'hF0);
      repeat (100) @(posedge clk);
      wr(16'hFFB8, 8'h7B);
      repeat (3) @(negedge clk);
      chk({busy, sck_out, done}, 3'h2);
      rd(16'hFFB8);
      chk(rd_v, 8'h03);
      // Slave: the bench makes eight pulses from an idle-high line
      wr(16'hFFB8, 8'h80);
      peer_tx <= 8'hC3;
      pulse_load;
      chk({sck_oe, so_oe}, 2'h1);
      wr(16'hFFB9, 8'h96);
      repeat (8) begin
         repeat (10) @(posedge clk);
         sck_ext <= 1'b0;
         repeat (10) @(posedge clk);
         sck_ext <= 1'b1;
      end
      wait_done(n);
      chk(peer_rx, 8'h96);
      rd(16'hFFB9);
      chk(rd_v, 8'hC3);
      // Fill the queue until refused, then count the frames that follow
      wr(16'hFFB8, 8'h00);
      wr(16'hFFB8, 8'h81);
      pulse_load;
      acc = 0;
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         addr <= 16'hFFB9;
         wdata <= 8'h10 + 8'(k);
         wr_s <= 1'b1;
         @(negedge clk);
         if (wr_ready === 1'b1) begin
            acc++;
            last = 8'h10 + 8'(k);
         end
      end
      @(posedge clk);
      wr_s <= 1'b0;
      fr = 0;
      pb = 1'b0;
      repeat (700) begin
         @(negedge clk);
         if (busy === 1'b1 && pb !== 1'b1) fr++;
         pb = busy;
      end
      chk(16'(fr), 16'(acc));
      chk(acc < 6, 1'b1);
      chk(peer_rx, last);
      final_report;
   end
endmodule
